// >>> src/mbd_host.sv
// Operation
// R1 - Device offers four bus modes: mux/non-mux, each 8 or 16 bit data.
// R2 - Multiplexed modes: device latches address phase with the address latch strobe.
// R3 - Mux 8-bit: low pins share address/data byte, high pins carry high address.
// R4 - Mux 16-bit: high pins also share high address/data byte.
// R5 - Non-mux: host drives full 16-bit address on the sixteen shared pins.
// R6 - Non-mux 8-bit: data byte travels through Port A.
// R7 - Non-mux 16-bit: Port A low data byte, Port B high data byte.
// R8 - Mux modes: Port A is I/O, latched address, or tracked low byte.
// R9 - Address bits 16-18 enter on Port C, bit 19 on shared pin.
// R10 - Mux host with data off low lines wires as non-mux, still drives strobe.
// R11 - Device holds two decode arrays; one makes internal selects.
// R12 - Second decode array drives selects out on Ports B and C.
// R13 - Both arrays see the same address, page, strobe and control inputs.
// R14 - Decode configuration lives in erasable non-volatile storage.
// R15 - Power-down input high in power-down use forces decode outputs inactive.
// R16 - Reset deasserts all decode outputs.
// R17 - Each Port C pin is either address input or select output.
// R18 - Each Port C pin direction is set individually.
// R19 - Latch strobe polarity is configurable; trailing edge captures the address.
// R20 - Shared pin used as address bit 19 is a plain decode input.
// R21 - Decode outputs are combinational in address and control inputs.
//
// Implementation choices: register access over AHB-Lite and the address map.
`default_nettype none
module mbd_host (
   input  wire logic        i_clock,         // 125 MHz clock
   input  wire logic        i_rst,           // Async reset, active high
   input  wire logic        i_hsel,          // AHB slave select
   input  wire logic [31:0] i_haddr,         // AHB address
   input  wire logic [1:0]  i_htrans,        // AHB transfer type
   input  wire logic        i_hwrite,        // AHB write
   input  wire logic [2:0]  i_hsize,         // AHB size (word only)
   input  wire logic        i_hready,        // AHB bus ready
   input  wire logic [31:0] i_hwdata,        // AHB write data
   output logic      [31:0] o_hrdata,        // AHB read data
   output logic             o_hreadyout,     // AHB slave ready
   output logic             o_hresp,         // AHB response, always OKAY
   input  wire logic [15:0] i_ad,            // Shared bus pins, level in
   output logic      [15:0] o_ad,            // Shared bus pins, level out
   output logic      [1:0]  o_ad_oe_n,       // Low/high byte enables, low drives
   input  wire logic [7:0]  i_port_a,        // Port A in
   output logic      [7:0]  o_port_a,        // Port A out
   output logic             o_port_a_oe_n,   // Port A enable, low drives
   input  wire logic [7:0]  i_port_b,        // Port B in (select outputs)
   output logic      [7:0]  o_port_b,        // Port B out
   output logic             o_port_b_oe_n,   // Port B enable, low drives
   input  wire logic [2:0]  i_port_c,        // Port C in (select outputs)
   output logic      [2:0]  o_port_c,        // Port C out (upper address)
   output logic      [2:0]  o_port_c_oe_n,   // Port C enables, low drives
   output logic             o_addr19_or_powerdown_pin, // Address bit 19 or standby
   output logic             o_address_latch_strobe,    // Address latch strobe
   output logic             o_rd_n,          // Read strobe, active low
   output logic             o_wr_n,          // Write strobe, active low
   output logic             o_byte_high_enable_n       // High byte enable, active low
);
   mbd_pkg::mbd_state_s q;
   mbd_pkg::mbd_state_s d;

   logic w16;
   logic nonmux;
   logic on_ports;
   logic ale_used;
   logic ale_on;

   assign w16      = q.ctrl[mbd_pkg::CTRL_W16];
   assign nonmux   = q.ctrl[mbd_pkg::CTRL_NONMUX];
   assign on_ports = nonmux | q.ctrl[mbd_pkg::CTRL_ALT];
   assign ale_used = ~nonmux | q.ctrl[mbd_pkg::CTRL_ALT];
   assign ale_on   = q.ctrl[mbd_pkg::CTRL_ALE_HI];

   function automatic logic [31:0] reg_read(input mbd_pkg::mbd_state_s s, input logic [2:0] idx);
      logic [31:0] v;
      v = 32'h0;
      unique case (idx)
         mbd_pkg::REG_CTRL:  v[15:0] = s.ctrl;
         mbd_pkg::REG_ADDR:  v[19:0] = s.addr;
         mbd_pkg::REG_WDATA: v[15:0] = s.wdata;
         mbd_pkg::REG_STATUS: begin
            v[mbd_pkg::ST_BUSY]         = (s.st != mbd_pkg::S_IDLE);
            v[mbd_pkg::ST_DONE]         = s.done;
            v[mbd_pkg::ST_SELB +: 8]    = s.sel_b;
            v[mbd_pkg::ST_SELC +: 3]    = s.sel_c;
         end
         mbd_pkg::REG_RDATA: v[15:0] = s.rdata;
         default:            v = 32'h0;
      endcase
      return v;
   endfunction

   always_comb begin
      logic start;
      logic idle;
      start = 1'b0;
      idle  = (q.st == mbd_pkg::S_IDLE);
      d = q;
      d.hreadyout = 1'b1;
      d.hresp     = 1'b0;
      // Two-stage synchronisers on every pin input
      d.ad_s1 = i_ad;
      d.ad_s2 = q.ad_s1;
      d.pa_s1 = i_port_a;
      d.pa_s2 = q.pa_s1;
      d.pb_s1 = i_port_b;
      d.pb_s2 = q.pb_s1;
      d.pc_s1 = i_port_c;
      d.pc_s2 = q.pc_s1;
      // Zero-wait slave: read data is taken at the address phase
      d.a_valid = i_hsel & i_htrans[1] & i_hready;
      d.a_we    = i_hwrite;
      d.a_idx   = i_haddr[4:2];
      if (d.a_valid && !i_hwrite) begin
         d.hrdata = reg_read(q, i_haddr[4:2]);
      end
      // Setup registers are frozen while a cycle runs so pins never change mid-cycle
      if (q.a_valid && q.a_we && idle) begin
         unique case (q.a_idx)
            mbd_pkg::REG_CTRL:  d.ctrl  = i_hwdata[15:0];
            mbd_pkg::REG_ADDR:  d.addr  = i_hwdata[19:0];
            mbd_pkg::REG_WDATA: d.wdata = i_hwdata[15:0];
            mbd_pkg::REG_CMD: begin
               start      = i_hwdata[mbd_pkg::CMD_GO];
               d.is_write = i_hwdata[mbd_pkg::CMD_WRITE];
            end
            default: ;
         endcase
      end
      unique case (q.st)
         mbd_pkg::S_IDLE: begin
            if (start) begin
               d.done    = 1'b0;
               d.st      = mbd_pkg::S_ADDR;
               d.cnt     = mbd_pkg::ADDR_CYC - 4'h1;
               d.ad      = q.addr[15:0];                                   // R5
               d.ad_oe_n = 2'b00;                                          // R5
               d.bhe_n   = ~w16;
               d.ale     = ale_used ? ale_on : ~ale_on;                    // R10
               for (int i = 0; i < 3; i++) begin
                  d.pc[i]      = q.addr[16 + i];                           // R9
                  d.pc_oe_n[i] = ~q.ctrl[mbd_pkg::CTRL_PC_EN + i];         // R9
               end
               d.a19 = q.ctrl[mbd_pkg::CTRL_A19_PD] ? q.ctrl[mbd_pkg::CTRL_PD_LVL]
                                                    : q.addr[19];          // R9
            end else begin
               // A polarity change must not leave the device latch open while idle
               d.ale = ~ale_on;
            end
         end
         mbd_pkg::S_ADDR: begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h0) begin
               // Trailing strobe edge here; address stays put through the hold
               d.ale = ~ale_on;
               d.st  = mbd_pkg::S_LATCH;
               d.cnt = mbd_pkg::HOLD_CYC - 4'h1;
            end
         end
         mbd_pkg::S_LATCH: begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h0) begin
               d.st   = mbd_pkg::S_STRB;
               d.cnt  = mbd_pkg::STRB_CYC - 4'h1;
               d.rd_n = q.is_write;
               d.wr_n = ~q.is_write;
               if (on_ports) begin
                  d.pa      = q.wdata[7:0];                                // R6
                  d.pa_oe_n = ~q.is_write;                                 // R6
                  d.pb      = q.wdata[15:8];                               // R7
                  d.pb_oe_n = ~(q.is_write & w16);                         // R7
               end else begin
                  d.ad[7:0]    = q.wdata[7:0];
                  d.ad_oe_n[0] = ~q.is_write;
                  if (w16) begin
                     d.ad[15:8]   = q.wdata[15:8];
                     d.ad_oe_n[1] = ~q.is_write;
                  end
               end
            end
         end
         mbd_pkg::S_STRB: begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h0) begin
               // Synchronised data lags the pins by two cycles; strobe is long enough
               if (!q.is_write) begin
                  d.rdata[7:0]  = on_ports ? q.pa_s2 : q.ad_s2[7:0];
                  d.rdata[15:8] = !w16 ? 8'h00 : (on_ports ? q.pb_s2 : q.ad_s2[15:8]);
               end
               d.sel_b = (nonmux && w16) ? 8'h00 : q.pb_s2;
               d.sel_c = q.pc_s2;
               d.rd_n  = 1'b1;
               d.wr_n  = 1'b1;
               d.st    = mbd_pkg::S_REC;
               d.cnt   = mbd_pkg::REC_CYC - 4'h1;
            end
         end
         mbd_pkg::S_REC: begin
            d.cnt = q.cnt - 4'h1;
            if (q.cnt == 4'h0) begin
               d.pa_oe_n = 1'b1;
               d.pb_oe_n = 1'b1;
               d.bhe_n   = 1'b1;
               if (!nonmux) begin
                  d.ad_oe_n = 2'b11;
               end
               d.done = 1'b1;
               d.st   = mbd_pkg::S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         q           <= '0;
         q.st        <= mbd_pkg::S_IDLE;
         q.ctrl      <= mbd_pkg::CTRL_RESET;
         q.hreadyout <= 1'b1;
         q.ad_oe_n   <= 2'b11;
         q.pa_oe_n   <= 1'b1;
         q.pb_oe_n   <= 1'b1;
         q.pc_oe_n   <= 3'b111;
         q.rd_n      <= 1'b1;
         q.wr_n      <= 1'b1;
         q.bhe_n     <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign o_hrdata                  = q.hrdata;
   assign o_hreadyout               = q.hreadyout;
   assign o_hresp                   = q.hresp;
   assign o_ad                      = q.ad;
   assign o_ad_oe_n                 = q.ad_oe_n;
   assign o_port_a                  = q.pa;
   assign o_port_a_oe_n             = q.pa_oe_n;
   assign o_port_b                  = q.pb;
   assign o_port_b_oe_n             = q.pb_oe_n;
   assign o_port_c                  = q.pc;
   assign o_port_c_oe_n             = q.pc_oe_n;
   assign o_addr19_or_powerdown_pin = q.a19;
   assign o_address_latch_strobe    = q.ale;
   assign o_rd_n                    = q.rd_n;
   assign o_wr_n                    = q.wr_n;
   assign o_byte_high_enable_n      = q.bhe_n;

   a_nonmux_address: assert property (@(posedge i_clock) disable iff (i_rst) // R5
      (q.st == mbd_pkg::S_STRB && nonmux)
      |-> (o_ad_oe_n == 2'b00 && o_ad == q.addr[15:0]))
      else $error("address pins not driven with address in non-mux mode");
   a_porta_data: assert property (@(posedge i_clock) disable iff (i_rst) // R6
      (q.st == mbd_pkg::S_LATCH && q.cnt == 4'h0 && on_ports && q.is_write)
      |=> (!o_port_a_oe_n && o_port_a == q.wdata[7:0])[*8])
      else $error("port A does not carry write data for whole strobe");
   a_portb_high: assert property (@(posedge i_clock) disable iff (i_rst) // R7
      (q.st == mbd_pkg::S_STRB && nonmux && w16 && q.is_write && !o_wr_n)
      |-> (!o_port_b_oe_n && o_port_b == q.wdata[15:8]))
      else $error("port B does not carry high write byte");
   a_upper_addr: assert property (@(posedge i_clock) disable iff (i_rst) // R9
      (q.st == mbd_pkg::S_STRB && !q.ctrl[mbd_pkg::CTRL_A19_PD])
      |-> (o_addr19_or_powerdown_pin == q.addr[19]
           && (o_port_c_oe_n[0] || o_port_c[0] == q.addr[16])))
      else $error("upper address bits wrong on port C or bit-19 pin");
   a_strobe_pulse: assert property (@(posedge i_clock) disable iff (i_rst) // R10
      (q.a_valid && q.a_we && q.a_idx == mbd_pkg::REG_CMD
       && q.st == mbd_pkg::S_IDLE && i_hwdata[mbd_pkg::CMD_GO] && ale_used)
      |=> (o_address_latch_strobe == ale_on)[*3]
          ##1 (o_address_latch_strobe != ale_on) ##[1:4] (!o_rd_n || !o_wr_n))
      else $error("latch strobe pulse missing or misplaced before data strobe");

   c_mux8_read: cover property (@(posedge i_clock) disable iff (i_rst)
      q.st == mbd_pkg::S_REC && !nonmux && !w16 && !q.is_write);
   c_nonmux16_write: cover property (@(posedge i_clock) disable iff (i_rst)
      q.st == mbd_pkg::S_STRB && nonmux && w16 && q.is_write);
   c_alt_wiring: cover property (@(posedge i_clock) disable iff (i_rst)
      q.st == mbd_pkg::S_STRB && !nonmux && q.ctrl[mbd_pkg::CTRL_ALT]);
endmodule // mbd_host
`default_nettype wire

// >>> src/mbd_pkg.sv
`default_nettype none
package mbd_pkg;
   // Register word indices (byte address = index * 4)
   localparam logic [2:0] REG_CTRL   = 3'h0;
   localparam logic [2:0] REG_ADDR   = 3'h1;
   localparam logic [2:0] REG_WDATA  = 3'h2;
   localparam logic [2:0] REG_CMD    = 3'h3;
   localparam logic [2:0] REG_STATUS = 3'h4;
   localparam logic [2:0] REG_RDATA  = 3'h5;
   // Control register fields
   localparam int CTRL_W16     = 0;
   localparam int CTRL_NONMUX  = 1;
   localparam int CTRL_ALE_HI  = 2;
   localparam int CTRL_ALT     = 3;
   localparam int CTRL_PC_EN   = 4;
   localparam int CTRL_A19_PD  = 7;
   localparam int CTRL_PD_LVL  = 8;
   localparam logic [15:0] CTRL_RESET = 16'h0004;
   // Command register fields
   localparam int CMD_GO    = 0;
   localparam int CMD_WRITE = 1;
   // Status register fields
   localparam int ST_BUSY  = 0;
   localparam int ST_DONE  = 1;
   localparam int ST_SELB  = 8;
   localparam int ST_SELC  = 16;
   // Bus phase timing
   localparam int CLK_NS    = 8;
   localparam int T_ADDR_NS = 20;
   localparam int T_HOLD_NS = 10;
   localparam int T_STRB_NS = 60;
   localparam int T_REC_NS  = 10;
   localparam logic [3:0] ADDR_CYC = 4'((T_ADDR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] STRB_CYC = 4'((T_STRB_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] REC_CYC  = 4'((T_REC_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {S_IDLE, S_ADDR, S_LATCH, S_STRB, S_REC} mbd_state_e;

   typedef struct packed {
      mbd_state_e  st;
      logic [3:0]  cnt;
      logic [15:0] ctrl;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        is_write;
      logic        done;
      logic [7:0]  sel_b;
      logic [2:0]  sel_c;
      logic [15:0] ad_s1;
      logic [15:0] ad_s2;
      logic [7:0]  pa_s1;
      logic [7:0]  pa_s2;
      logic [7:0]  pb_s1;
      logic [7:0]  pb_s2;
      logic [2:0]  pc_s1;
      logic [2:0]  pc_s2;
      logic        a_valid;
      logic        a_we;
      logic [2:0]  a_idx;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
      logic [15:0] ad;
      logic [1:0]  ad_oe_n;
      logic [7:0]  pa;
      logic        pa_oe_n;
      logic [7:0]  pb;
      logic        pb_oe_n;
      logic [2:0]  pc;
      logic [2:0]  pc_oe_n;
      logic        a19;
      logic        ale;
      logic        rd_n;
      logic        wr_n;
      logic        bhe_n;
   } mbd_state_s;
endpackage
`default_nettype wire

// >>> tb/mbd_dev_model.sv
`default_nettype none
module mbd_dev_model (
   input  wire logic        i_rst,     // Device reset
   input  wire logic        i_nonmux,  // Non-mux or alt wiring
   input  wire logic        i_alt,     // Mux host wired as non-mux
   input  wire logic        i_w16,     // 16-bit data
   input  wire logic        i_ale_hi,  // Strobe active level
   input  wire logic        i_pd_mode, // Shared pin used as power-down
   input  wire logic [15:0] i_ad,      // Shared pin levels
   input  wire logic [7:0]  i_pa,      // Port A levels
   input  wire logic [7:0]  i_pb,      // Port B levels
   input  wire logic [2:0]  i_pc,      // Port C levels
   input  wire logic        i_a19,     // Bit-19 or power-down pin
   input  wire logic        i_ale,     // Address latch strobe
   input  wire logic        i_rd_n,    // Read strobe
   input  wire logic        i_wr_n,    // Write strobe
   output logic      [15:0] o_ad,      // Read data for shared pins
   output logic      [1:0]  o_ad_en,   // Shared byte lanes driven
   output logic      [15:0] o_pab,     // Port B and A drive
   output logic      [1:0]  o_pab_en,  // Port B, Port A driven
   output logic      [2:0]  o_selc,    // Port C select outputs
   output logic      [19:0] o_addr     // Address seen by decode
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [19:0] alat;
   logic [15:0] mem [16];
   logic [15:0] rd_word;
   logic [7:0]  sel_b;
   logic        stby;
   logic        rd_on;
   logic        nm16;
   // Transparent while the strobe is active, holds from its trailing edge
   always_latch begin
      if (i_ale == i_ale_hi) alat <= {i_a19, i_pc, i_ad};
   end
   // Alt wiring still latches, so the address must survive the host releasing the pins
   assign o_addr   = (i_nonmux && !i_alt) ? {i_a19, i_pc, i_ad} : alat;
   assign stby     = i_rst | (i_pd_mode & i_a19);
   assign rd_on    = !i_rd_n && !stby;
   assign nm16     = i_nonmux && i_w16;
   assign rd_word  = mem[o_addr[3:0]];
   // Select outputs follow the inputs with no clock, valid from power-up
   assign sel_b    = stby ? 8'hff : ~(8'h01 << o_addr[15:13]);
   assign o_selc   = stby ? 3'h7 : ~(3'h1 << o_addr[11:10]);
   assign o_ad     = rd_word;
   assign o_ad_en  = (!i_nonmux && rd_on) ? {i_w16, 1'b1} : 2'b00;
   // Port B carries data only in non-mux 16-bit; otherwise it keeps showing selects
   assign o_pab    = {(nm16 && rd_on) ? rd_word[15:8] : sel_b,
                      (i_nonmux && rd_on) ? rd_word[7:0] : 8'h00};
   // In mux modes Port A stays general I/O and is left undriven
   assign o_pab_en = {(nm16 && rd_on) || !nm16, i_nonmux && rd_on};
   always @(posedge i_wr_n) begin
      if (!i_rst && !stby) begin
         mem[o_addr[3:0]] <= i_nonmux ? {i_w16 ? i_pb : 8'h00, i_pa}
                                      : {i_w16 ? i_ad[15:8] : 8'h00, i_ad[7:0]};
      end
   end
endmodule // mbd_dev_model
`default_nettype wire

// >>> tb/mbd_host_tb_top.sv
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %0t: got %h exp %h", $time, (g), (e)); end end
module mbd_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready;
   logic        cfg_nm = 1'b0, cfg_w16 = 1'b0, cfg_hi = 1'b1, cfg_pd = 1'b0;
   logic        cfg_alt = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, got, e;
   logic [1:0]  htrans = '0, ad_oe_n, m_ad_en, m_pab_en;
   logic [15:0] ad_o, ad_in, m_ad, m_pab, ctl, wd, e8;
   logic [7:0]  pa_o, pa_in, pb_o, pb_in, sb;
   logic [2:0]  pc_o, pc_in, pc_oe_n, m_selc, sc;
   logic        pa_oe_n, pb_oe_n, a19, ale, rd_n, wr_n, bhe_n;
   logic [19:0] a, m_addr;
   int          seed, n_mismatch = 0, check_count = 0;
   logic [31:0] exp_q [$];
   event        rd_ev;
   logic [15:0] modes [9] = '{16'h0004, 16'h0005, 16'h0006, 16'h0077, 16'h0000,
                              16'h000c, 16'h0184, 16'h0084, 16'h0074};

   mbd_host uut (.i_clock(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
      .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
      .i_ad(ad_in), .o_ad(ad_o), .o_ad_oe_n(ad_oe_n), .i_port_a(pa_in), .o_port_a(pa_o),
      .o_port_a_oe_n(pa_oe_n), .i_port_b(pb_in), .o_port_b(pb_o), .o_port_b_oe_n(pb_oe_n),
      .i_port_c(pc_in), .o_port_c(pc_o), .o_port_c_oe_n(pc_oe_n),
      .o_addr19_or_powerdown_pin(a19), .o_address_latch_strobe(ale), .o_rd_n(rd_n),
      .o_wr_n(wr_n), .o_byte_high_enable_n(bhe_n));

   mbd_dev_model dev (.i_rst(rst), .i_nonmux(cfg_nm), .i_alt(cfg_alt), .i_w16(cfg_w16),
      .i_ale_hi(cfg_hi),
      .i_pd_mode(cfg_pd), .i_ad(ad_in), .i_pa(pa_in), .i_pb(pb_in), .i_pc(pc_in),
      .i_a19(a19), .i_ale(ale), .i_rd_n(rd_n), .i_wr_n(wr_n), .o_ad(m_ad),
      .o_ad_en(m_ad_en), .o_pab(m_pab), .o_pab_en(m_pab_en), .o_selc(m_selc),
      .o_addr(m_addr));

   // Released lines show the inverse of the last driven value, never a stale copy
   assign ad_in[7:0]  = !ad_oe_n[0] ? ad_o[7:0] : m_ad_en[0] ? m_ad[7:0] : ~ad_o[7:0];
   assign ad_in[15:8] = !ad_oe_n[1] ? ad_o[15:8] : m_ad_en[1] ? m_ad[15:8] : ~ad_o[15:8];
   assign pa_in = !pa_oe_n ? pa_o : m_pab_en[0] ? m_pab[7:0] : ~pa_o;
   assign pb_in = !pb_oe_n ? pb_o : m_pab_en[1] ? m_pab[15:8] : ~pb_o;
   always_comb begin
      for (int i = 0; i < 3; i++) pc_in[i] = !pc_oe_n[i] ? pc_o[i] : m_selc[i];
   end

   initial begin
      forever #4 clk = ~clk;
   end

   task automatic ahb(input logic [31:0] ad, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [4:0] ad, input logic [31:0] d);
      logic [31:0] r;
      ahb({27'h0, ad}, 1'b1, d, r);
   endtask

   task automatic rd_chk(input logic [4:0] ad, input logic [31:0] x);
      exp_q.push_back(x);
      ahb({27'h0, ad}, 1'b0, 32'h0, got);
      -> rd_ev;
   endtask

   // Polls under a bound; a missing done shows up in the checks that follow
   task automatic run(input logic w);
      logic [31:0] s;
      int n;
      wr(5'h0c, {30'h0, w, 1'b1});
      n = 0;
      s = '0;
      while (s[1] !== 1'b1 && n < 40) begin
         ahb(32'h10, 1'b0, 32'h0, s);
         n++;
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      forever begin
         @(rd_ev);
         e = exp_q.pop_front();
         `CHK(got, e)
      end
   end

   initial begin
      #400000;
      n_mismatch++;
      final_report();
   end

   initial begin
      seed = 32'h1d61;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk(5'h00, 32'h0000_0004);
      wr(5'h1c, 32'hffff_ffff);
      rd_chk(5'h1c, 32'h0);
      rd_chk(5'h0c, 32'h0);
      foreach (modes[i]) begin
         ctl = modes[i];
         a = 20'($random(seed));
         wd = 16'($random(seed));
         if (ctl[7]) a[19] = ctl[8];
         cfg_nm <= ctl[1] | ctl[3];
         cfg_alt <= ctl[3];
         cfg_w16 <= ctl[0];
         cfg_hi <= ctl[2];
         cfg_pd <= ctl[7];
         wr(5'h00, {16'h0, ctl});
         wr(5'h04, {12'h0, a});
         wr(5'h08, {16'h0, wd});
         run(1'b1);
         `CHK(m_addr[15:0], a[15:0])
         if (ctl[6:4] == 3'h7) `CHK(m_addr[19:16], a[19:16])
         run(1'b0);
         e8 = ctl[0] ? wd : {8'h00, wd[7:0]};
         if (!(ctl[7] && ctl[8])) rd_chk(5'h14, {16'h0, e8});
         sb = (ctl[7] && ctl[8]) ? 8'hff : ~(8'h01 << a[15:13]);
         if (ctl[1] && ctl[0]) sb = 8'h00;
         sc = (ctl[7] && ctl[8]) ? 3'h7 : ~(3'h1 << a[11:10]);
         if (ctl[6:4] == 3'h7) sc = a[18:16];
         rd_chk(5'h10, {13'h0, sc, sb, 6'h0, 2'b10});
      end
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK({pb_in, pc_in}, 11'h7ff)
      rst <= 1'b0;
      rd_chk(5'h00, 32'h0000_0004);
      repeat (3) @(posedge clk);
      final_report();
   end
endmodule // mbd_host_tb_top
`default_nettype wire
